// ---- hw/sdcf_crc7.sv ----
`default_nettype none

module sdcf_crc7 (
	// Clock and reset
	input wire logic   clk,
	input wire logic   rstn,
	// Serial CRC port
	sdcf_crc_if.engine crc_bus
);
	import sdcf_pkg::*;

	logic [6:0] crc_q;
	logic [6:0] crc_d;
	logic       fb;

	// ----------------------------------------
	// Generator x^7 + x^3 + 1, MSB first
	// ----------------------------------------
	assign fb          = crc_bus.din ^ crc_q[6];
	assign crc_d       = {crc_q[5:0], 1'b0} ^ (fb ? CRC7_POLY : CRC7_ZERO);
	assign crc_bus.crc = crc_q;

	// Clear wins so each frame starts from an all-zero remainder
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			crc_q <= CRC7_ZERO;
		else if (crc_bus.clr)
			crc_q <= CRC7_ZERO;
		else if (crc_bus.en)
			crc_q <= crc_d;
	end

endmodule

`default_nettype wire

// ---- hw/sdcf_crc_if.sv ----
`default_nettype none

// Serial CRC7 engine hookup
interface sdcf_crc_if;
	logic       clr;
	logic       en;
	logic       din;
	logic [6:0] crc;
	modport user   (output clr, output en, output din, input crc);
	modport engine (input clr, input en, input din, output crc);
endinterface

`default_nettype wire

// ---- hw/sdcf_framer.sv ----
// What this block does
// - short 48-bit and long 136-bit responses are both received and checked, by CRC7 or for an all-ones field
// - short response: 0, 0, index, argument, CRC7 or all ones, end 1
// - long response: 0, 0, reserved 111111, contents in bits 127..1, end 1
// - bc commands expect no response, except index 1
// - bcr commands expect a response from the cards
// - ac commands address one card with no data line transfer
// - adtc commands address one card with a data line transfer
// - index 0 is bc with no response, returning cards to idle
// - index 1 is bc and expects an operating condition response
// - index 2 is bcr and expects a long identification response
// - index 4 is bc with no response, drive stage in bits 31..16
// - index 5 is bcr with the I/O operating condition response
// - index 6 is ac with a busy-type short response
// - index 7 is ac with a busy-type short response, card select
// - index 8 is bcr; argument bits 31..12 are forced to zero
// - indices 9 and 10 are ac and expect a long response
// - index 12 is ac with a busy-type short response, stops transfer
// - index 13 is ac and expects a short status response
// - index 14 is adtc with a short response
// - index 19 is adtc with a short response
// - index 15 is ac with no response
`default_nettype none

module sdcf_framer (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Command request
	input  wire logic                cmd_valid,
	input  wire logic [5:0]          cmd_index,
	input  wire logic [31:0]         cmd_arg,
	output logic                     cmd_ready,
	// Command class of the accepted command
	output var sdcf_pkg::sdcf_ctype_e cmd_type,
	output logic                     data_xfer,
	output logic                     busy_expected,
	// Result
	output logic                     done,
	output logic                     rsp_got,
	output logic [5:0]               rsp_index,
	output logic [127:0]             rsp_data,
	output logic                     crc_err,
	output logic                     frame_err,
	output logic                     timeout,
	// Card pins
	output logic                     sd_clk,
	output logic                     cmd_o,
	output logic                     cmd_oe,
	input  wire logic                cmd_i
);
	import sdcf_pkg::*;

	sdcf_crc_if crc_bus ();

	sdcf_st_e    st_q, st_d;
	sdcf_info_s  info_q, info_new;
	logic [2:0]  div_q;
	logic        sd_clk_q, cmd_s1_q, cmd_s2_q;
	logic [47:0] tx_q;
	logic [7:0]  bit_q, rx_n_q, tmo_q, drv_cnt_q;
	logic [135:0] rx_q;
	logic        tmo_hit_q, cmd_o_q, cmd_oe_q, cmd_ready_q;
	logic        done_q, got_q, crc_err_q, frame_err_q, timeout_q;
	logic        data_xfer_q, busy_q;
	sdcf_ctype_e cmd_type_q;
	logic [5:0]  rsp_index_q;
	logic [127:0] rsp_data_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Command classification table
	// ----------------------------------------
	// Unlisted indices are treated as ac with a checked short response
	function automatic sdcf_info_s info_of(input logic [5:0] idx);
		sdcf_info_s r;
		r = '{CT_AC, RSP_SHORT, 1'b0};
		case (idx)
			CMD_GO_IDLE:  r = '{CT_BC, RSP_NONE, 1'b0};
			CMD_OP_COND:  r = '{CT_BC, RSP_SHORT_NOCRC, 1'b0};
			CMD_ALL_ID:   r = '{CT_BCR, RSP_LONG, 1'b0};
			CMD_REL_ADDR: r = '{CT_BCR, RSP_SHORT, 1'b0};
			CMD_DRIVE:    r = '{CT_BC, RSP_NONE, 1'b0};
			CMD_IO_OP:    r = '{CT_BCR, RSP_SHORT_NOCRC, 1'b0};
			CMD_SWITCH:   r = '{CT_AC, RSP_SHORT, 1'b1};
			CMD_SELECT:   r = '{CT_AC, RSP_SHORT, 1'b1};
			CMD_IF_COND:  r = '{CT_BCR, RSP_SHORT, 1'b0};
			CMD_GET_SPEC: r = '{CT_AC, RSP_LONG, 1'b0};
			CMD_GET_ID:   r = '{CT_AC, RSP_LONG, 1'b0};
			CMD_STOP:     r = '{CT_AC, RSP_SHORT, 1'b1};
			CMD_STATUS:   r = '{CT_AC, RSP_SHORT, 1'b0};
			CMD_TEST_RD:  r = '{CT_ADTC, RSP_SHORT, 1'b0};
			CMD_TEST_WR:  r = '{CT_ADTC, RSP_SHORT, 1'b0};
			CMD_INACTIVE: r = '{CT_AC, RSP_NONE, 1'b0};
			default:      r = '{CT_AC, RSP_SHORT, 1'b0};
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Decode and selection
	// ----------------------------------------
	logic        accept, div_wrap, fall_en, rise_en, tx_end, tx_drive, tx_bit;
	logic        tx_release, tx_payload, rx_start, rx_take, rx_last, rx_feed;
	logic        tmo_fire, is_long, nocrc, got, crc_bad, frame_bad, dir_bit;
	logic [2:0]  crc_sel;
	logic [6:0]  crc_val, crc_field;
	logic [31:0] arg_tx;

	assign accept     = cmd_valid & cmd_ready_q;
	assign info_new   = info_of(cmd_index);
	// Card samples on the rising edge, so we change the line on the falling one
	assign div_wrap   = div_q == HALF_LAST;
	assign fall_en    = div_wrap & sd_clk_q;
	assign rise_en    = div_wrap & ~sd_clk_q;
	// Reserved high argument bits of the interface condition command
	assign arg_tx     = (cmd_index == CMD_IF_COND) ? {ARG8_ZERO, cmd_arg[11:0]} : cmd_arg;
	assign tx_end     = bit_q == BIT_DONE;
	assign tx_drive   = (st_q == ST_TX) & fall_en & ~tx_end;
	assign tx_release = (st_q == ST_TX) & fall_en & tx_end;
	assign tx_payload = bit_q >= POS_PAY_LO;
	assign crc_sel    = bit_q[2:0] - 3'h1;
	assign crc_val    = crc_bus.crc;
	assign tx_bit     = tx_payload ? tx_q[bit_q[5:0]] :
	                    (bit_q == POS_END) ? BIT_END : crc_val[crc_sel];
	assign is_long    = info_q.rsp == RSP_LONG;
	assign nocrc      = info_q.rsp == RSP_SHORT_NOCRC;
	assign rx_start   = rise_en & (st_q == ST_WAIT) & ~cmd_s2_q;
	assign rx_take    = rx_start | (rise_en & (st_q == ST_RX));
	assign rx_last    = rx_n_q == (is_long ? LONG_LAST : SHORT_LAST);
	// Long responses check only the contents ahead of the CRC field
	assign rx_feed    = is_long ? (rx_n_q >= LCRC_FIRST && rx_n_q <= LCRC_LAST)
	                            : (rx_n_q <= SCRC_LAST);
	assign tmo_fire   = rise_en & (st_q == ST_WAIT) & cmd_s2_q & (tmo_q == TMO_LAST);

	// Serial CRC shared by transmit and receive; they never overlap
	assign crc_bus.clr = accept | tx_release;
	assign crc_bus.en  = (tx_drive & tx_payload) | (rx_take & rx_feed);
	assign crc_bus.din = (st_q == ST_TX) ? tx_bit : cmd_s2_q;

	// Result checks on the captured frame
	assign got        = (info_q.rsp != RSP_NONE) & ~tmo_hit_q;
	assign crc_field  = rx_q[7:1];
	assign crc_bad    = got & (nocrc ? (crc_field != CRC_ALLONES) : (crc_field != crc_val));
	assign dir_bit    = is_long ? rx_q[134] : rx_q[46];
	assign frame_bad  = got & (dir_bit | ~rx_q[0] |
	                    (is_long & (rx_q[133:128] != LONG_RSV)));

	sdcf_crc7 u_crc (
		.clk     (clk),
		.rstn    (rstn),
		.crc_bus (crc_bus.engine)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: if (accept) st_d = ST_TX;
			ST_TX:   if (tx_release) st_d = (info_q.rsp == RSP_NONE) ? ST_DONE : ST_WAIT;
			ST_WAIT:
			begin
				if (rx_start)
					st_d = ST_RX;
				else if (tmo_fire)
					st_d = ST_DONE;
			end
			ST_RX:   if (rx_take && rx_last) st_d = ST_DONE;
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_q <= ST_IDLE;
		else
			st_q <= st_d;
	end

	// Card clock divider; runs free so the card always sees a clock
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q    <= 3'h0;
			sd_clk_q <= 1'b0;
		end
		else
		begin
			div_q    <= div_wrap ? 3'h0 : div_q + 3'h1;
			sd_clk_q <= div_wrap ? ~sd_clk_q : sd_clk_q;
		end
	end

	// Command line input synchroniser
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_s1_q <= 1'b1;
			cmd_s2_q <= 1'b1;
		end
		else
		begin
			cmd_s1_q <= cmd_i;
			cmd_s2_q <= cmd_s1_q;
		end
	end

	// ----------------------------------------
	// Transmit shifter
	// ----------------------------------------
	// One bit per falling edge, then one more edge holding the end bit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_q     <= 48'h0;
			bit_q    <= BIT_DONE;
			cmd_o_q  <= 1'b1;
			cmd_oe_q <= 1'b0;
		end
		else if (accept)
		begin
			tx_q  <= {BIT_START, BIT_DIR_CMD, cmd_index, arg_tx, CRC7_ZERO, BIT_END};
			bit_q <= POS_START;
		end
		else if (tx_drive)
		begin
			cmd_o_q  <= tx_bit;
			cmd_oe_q <= 1'b1;
			bit_q    <= (bit_q == POS_END) ? BIT_DONE : bit_q - 8'h01;
		end
		else if (tx_release)
		begin
			cmd_o_q  <= 1'b1;
			cmd_oe_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Receive shifter and timeout
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_q      <= 136'h0;
			rx_n_q    <= 8'h00;
			tmo_q     <= 8'h00;
			tmo_hit_q <= 1'b0;
		end
		else if (accept)
		begin
			rx_q      <= 136'h0;
			rx_n_q    <= 8'h00;
			tmo_q     <= 8'h00;
			tmo_hit_q <= 1'b0;
		end
		else if (rx_take)
		begin
			rx_q   <= {rx_q[134:0], cmd_s2_q};
			rx_n_q <= rx_n_q + 8'h01;
		end
		else if (rise_en && st_q == ST_WAIT)
		begin
			tmo_q     <= tmo_q + 8'h01;
			tmo_hit_q <= tmo_fire;
		end
	end

	// ----------------------------------------
	// Handshake and result registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_ready_q <= 1'b1;
			info_q      <= '{CT_BC, RSP_NONE, 1'b0};
			cmd_type_q  <= CT_BC;
			data_xfer_q <= 1'b0;
			busy_q      <= 1'b0;
		end
		else
		begin
			cmd_ready_q <= st_d == ST_IDLE;
			if (accept)
			begin
				info_q      <= info_new;
				cmd_type_q  <= info_new.ctype;
				data_xfer_q <= info_new.ctype == CT_ADTC;
				busy_q      <= info_new.busy;
			end
		end
	end

	// Results load together so software never sees a mixed set
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			done_q      <= 1'b0;
			got_q       <= 1'b0;
			crc_err_q   <= 1'b0;
			frame_err_q <= 1'b0;
			timeout_q   <= 1'b0;
			rsp_index_q <= 6'h00;
			rsp_data_q  <= 128'h0;
		end
		else
		begin
			done_q <= st_q == ST_DONE;
			if (st_q == ST_DONE)
			begin
				got_q       <= got;
				crc_err_q   <= crc_bad;
				frame_err_q <= frame_bad;
				timeout_q   <= tmo_hit_q;
				rsp_index_q <= rx_q[45:40];
				rsp_data_q  <= is_long ? rx_q[127:0] : {96'h0, rx_q[39:8]};
			end
		end
	end

	assign cmd_ready     = cmd_ready_q;
	assign cmd_type      = cmd_type_q;
	assign data_xfer     = data_xfer_q;
	assign busy_expected = busy_q;
	assign done          = done_q;
	assign rsp_got       = got_q;
	assign rsp_index     = rsp_index_q;
	assign rsp_data      = rsp_data_q;
	assign crc_err       = crc_err_q;
	assign frame_err     = frame_err_q;
	assign timeout       = timeout_q;
	assign sd_clk        = sd_clk_q;
	assign cmd_o         = cmd_o_q;
	assign cmd_oe        = cmd_oe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Counts bits driven in the current frame
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			drv_cnt_q <= 8'h00;
		else if (accept)
			drv_cnt_q <= 8'h00;
		else if (tx_drive)
			drv_cnt_q <= drv_cnt_q + 8'h01;
	end

	sequence s_result;
		##1 done_q ##1 !done_q;
	endsequence

	a_frame_len: assert property ($fell(cmd_oe_q) |-> drv_cnt_q == 8'h30)
		else $error("command frame not 48 bits");
	a_start_low: assert property ($rose(cmd_oe_q) |-> !cmd_o_q)
		else $error("start bit not low");
	a_dir_high: assert property (tx_drive && bit_q == POS_DIR |=> cmd_o_q)
		else $error("direction bit not high");
	a_end_high: assert property (tx_drive && bit_q == POS_END |=> cmd_o_q ##8 !cmd_oe_q)
		else $error("end bit wrong or not released");
	a_crc_first: assert property (tx_drive && bit_q == POS_CRC_HI |=> cmd_o_q == crc_val[6])
		else $error("CRC MSB wrong");
	a_no_rsp: assert property (tx_release && info_q.rsp == RSP_NONE |=> s_result ##0 1)
		else $error("no-response command not finished at once");
	a_timeout_flag: assert property (tmo_fire |=> s_result and (##1 timeout_q && !rsp_got))
		else $error("timeout not reported");
	a_crc_flag: assert property (st_q == ST_DONE && got && !nocrc &&
		crc_field != crc_val |=> crc_err_q)
		else $error("CRC mismatch not flagged");
	a_ones_ok: assert property (st_q == ST_DONE && got && nocrc && crc_field == CRC_ALLONES
		|=> !crc_err_q)
		else $error("all-ones field flagged as CRC error");
	a_long_rsv: assert property (st_q == ST_DONE && got && is_long &&
		rx_q[133:128] != LONG_RSV |=> frame_err_q)
		else $error("bad reserved bits not flagged");
	a_adtc_data: assert property (accept && info_new.ctype == CT_ADTC |=> data_xfer_q)
		else $error("adtc not marked as data transfer");
	a_ac_nodata: assert property (accept && info_new.ctype == CT_AC |=> !data_xfer_q)
		else $error("ac marked as data transfer");
	a_arg8_zero: assert property (accept && cmd_index == CMD_IF_COND
		|=> tx_q[39:20] == ARG8_ZERO)
		else $error("reserved argument bits not zero");

endmodule

`default_nettype wire

// ---- hw/sdcf_pkg.sv ----
`default_nettype none

package sdcf_pkg;

	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned SDCLK_HZ    = 12_500_000;
	// Half period of the card clock in system cycles, minus one
	localparam logic [2:0]  HALF_LAST   = 3'(CLK_HZ / (2 * SDCLK_HZ) - 1);
	// Bus clocks allowed between end of command and response start bit
	localparam int unsigned NCR_CLOCKS  = 64;
	localparam logic [7:0]  TMO_LAST    = 8'(NCR_CLOCKS - 1);

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam logic        BIT_START   = 1'b0;
	localparam logic        BIT_DIR_CMD = 1'b1;
	localparam logic        BIT_END     = 1'b1;
	localparam logic [7:0]  POS_START   = 8'h2F;
	localparam logic [7:0]  POS_DIR     = 8'h2E;
	localparam logic [7:0]  POS_CRC_HI  = 8'h07;
	localparam logic [7:0]  POS_PAY_LO  = 8'h08;
	localparam logic [7:0]  POS_END     = 8'h00;
	localparam logic [7:0]  BIT_DONE    = 8'hFF;
	localparam logic [7:0]  SHORT_LAST  = 8'h2F;
	localparam logic [7:0]  LONG_LAST   = 8'h87;
	localparam logic [7:0]  SCRC_LAST   = 8'h27;
	localparam logic [7:0]  LCRC_FIRST  = 8'h08;
	localparam logic [7:0]  LCRC_LAST   = 8'h7F;
	localparam logic [5:0]  LONG_RSV    = 6'h3F;
	localparam logic [6:0]  CRC_ALLONES = 7'h7F;
	localparam logic [6:0]  CRC7_POLY   = 7'h09;
	localparam logic [6:0]  CRC7_ZERO   = 7'h00;
	localparam logic [19:0] ARG8_ZERO   = 20'h0_0000;

	// ----------------------------------------
	// Command indices
	// ----------------------------------------
	localparam logic [5:0]  CMD_GO_IDLE  = 6'h00;
	localparam logic [5:0]  CMD_OP_COND  = 6'h01;
	localparam logic [5:0]  CMD_ALL_ID   = 6'h02;
	localparam logic [5:0]  CMD_REL_ADDR = 6'h03;
	localparam logic [5:0]  CMD_DRIVE    = 6'h04;
	localparam logic [5:0]  CMD_IO_OP    = 6'h05;
	localparam logic [5:0]  CMD_SWITCH   = 6'h06;
	localparam logic [5:0]  CMD_SELECT   = 6'h07;
	localparam logic [5:0]  CMD_IF_COND  = 6'h08;
	localparam logic [5:0]  CMD_GET_SPEC = 6'h09;
	localparam logic [5:0]  CMD_GET_ID   = 6'h0A;
	localparam logic [5:0]  CMD_STOP     = 6'h0C;
	localparam logic [5:0]  CMD_STATUS   = 6'h0D;
	localparam logic [5:0]  CMD_TEST_RD  = 6'h0E;
	localparam logic [5:0]  CMD_INACTIVE = 6'h0F;
	localparam logic [5:0]  CMD_TEST_WR  = 6'h13;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		CT_BC   = 2'b00,
		CT_BCR  = 2'b01,
		CT_AC   = 2'b10,
		CT_ADTC = 2'b11
	} sdcf_ctype_e;

	typedef enum logic [1:0] {
		RSP_NONE        = 2'b00,
		RSP_SHORT       = 2'b01,
		RSP_SHORT_NOCRC = 2'b10,
		RSP_LONG        = 2'b11
	} sdcf_rsp_e;

	typedef struct packed {
		sdcf_ctype_e ctype;
		sdcf_rsp_e   rsp;
		logic        busy;
	} sdcf_info_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TX   = 3'b001,
		ST_WAIT = 3'b010,
		ST_RX   = 3'b011,
		ST_DONE = 3'b100
	} sdcf_st_e;

endpackage

`default_nettype wire

// ---- tb/sdcf_card_model.sv ----
`default_nettype none

module sdcf_card_model (
	// Card pins
	input  wire logic        sd_clk,
	input  wire logic        cmd_line,
	output logic             card_o,
	output logic             card_oe,
	// Bench control
	input  wire logic [7:0]  dly,
	input  wire logic [1:0]  fault,
	// Last command seen
	output logic [5:0]       rx_index,
	output logic [31:0]      rx_arg,
	output logic             rx_ok,
	output logic [7:0]       rx_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Checksum and answer choice
	// ----------------------------------------
	// Serial CRC7 over the low n bits of d, MSB first, from a zero remainder
	function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
		logic [6:0] c;
		c = 7'h00;
		for (int i = n - 1; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction

	// Answer kind: 0 none, 1 short, 2 short with all ones, 3 long
	function automatic logic [1:0] kind_of(input logic [5:0] idx);
		case (idx)
			6'h00, 6'h04, 6'h0F: return 2'h0;
			6'h01, 6'h05:        return 2'h2;
			6'h02, 6'h09, 6'h0A: return 2'h3;
			default:             return 2'h1;
		endcase
	endfunction

	// ----------------------------------------
	// Card behaviour
	// ----------------------------------------
	// Listens on rising card clock edges and drives on falling ones, so each
	// bit is settled half a period before anyone samples it
	logic [135:0] r;
	logic [47:0]  f;
	logic [127:0] lp;
	logic [6:0]   c;
	logic [1:0]   k;
	int           n;
	initial
	begin
		card_o   = 1'b1;
		card_oe  = 1'b0;
		rx_index = 6'h00;
		rx_arg   = 32'h0000_0000;
		rx_ok    = 1'b0;
		rx_cnt   = 8'h00;
		forever
		begin
			@(posedge sd_clk);
			if (cmd_line === 1'b0)
			begin
				f[47] = 1'b0;
				for (int i = 46; i >= 0; i--)
				begin
					@(posedge sd_clk);
					f[i] = cmd_line;
				end
				rx_index = f[45:40];
				rx_arg   = f[39:8];
				c        = crc7({80'h0, f[47:8]}, 40);
				rx_ok    = (f[46] === 1'b1) && (f[0] === 1'b1) && (f[7:1] === c);
				rx_cnt   = rx_cnt + 8'h01;
				k        = kind_of(rx_index);
				lp       = {~rx_arg, rx_arg, ~rx_arg, rx_arg};
				if (k == 2'h3)
				begin
					r = {8'h3F, lp[127:8], crc7(lp[127:8], 120), 1'b1};
					n = 136;
				end
				else
				begin
					c = (k == 2'h2) ? 7'h7F : crc7({82'h0, rx_index, ~rx_arg}, 40);
					r = {90'h0, rx_index, ~rx_arg, c, 1'b1};
					n = 48;
				end
				// Faults that the bench asks for: bad checksum or bad end bit
				if (fault == 2'h1)
					r[1] = ~r[1];
				// Long answers also lose a reserved bit so that check is reached too
				if (fault == 2'h3)
				begin
					r[0]   = 1'b0;
					r[133] = (k == 2'h3) ? 1'b0 : r[133];
				end
				if (k != 2'h0 && fault != 2'h2)
				begin
					repeat (dly) @(negedge sd_clk);
					for (int i = n - 1; i >= 0; i--)
					begin
						card_oe = 1'b1;
						card_o  = r[i];
						@(negedge sd_clk);
					end
					card_oe = 1'b0;
					card_o  = 1'b1;
				end
			end
		end
	end
endmodule

`default_nettype wire

// ---- tb/sdcf_framer_tb_top.sv ----
`default_nettype none

module sdcf_framer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sdcf_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic         clk, rstn, cmd_valid, cmd_ready, data_xfer, busy_expected;
	logic         done, rsp_got, crc_err, frame_err, timeout, sd_clk, cmd_o, cmd_oe;
	logic [5:0]   cmd_index, rsp_index, rx_index;
	logic [31:0]  cmd_arg, rx_arg;
	logic [127:0] rsp_data;
	sdcf_ctype_e  cmd_type;
	logic         card_o, card_oe, rx_ok, oe_prev;
	logic [7:0]   dly, rx_cnt;
	logic [1:0]   fault;
	logic [15:0]  oe_len;
	wire logic    cmd_line;
	int           error_cnt, total_checks;

`define CHK(nm, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
			error_cnt++; \
		end \
	end

	// Pulled-up command line: low only where someone drives a 0
	assign cmd_line = (cmd_oe ? cmd_o : 1'b1) & (card_oe ? card_o : 1'b1);

	sdcf_framer u_dut (
		.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
		.cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .cmd_type(cmd_type),
		.data_xfer(data_xfer), .busy_expected(busy_expected), .done(done),
		.rsp_got(rsp_got), .rsp_index(rsp_index), .rsp_data(rsp_data),
		.crc_err(crc_err), .frame_err(frame_err), .timeout(timeout),
		.sd_clk(sd_clk), .cmd_o(cmd_o), .cmd_oe(cmd_oe), .cmd_i(cmd_line)
	);

	sdcf_card_model u_card (
		.sd_clk(sd_clk), .cmd_line(cmd_line), .card_o(card_o), .card_oe(card_oe),
		.dly(dly), .fault(fault), .rx_index(rx_index), .rx_arg(rx_arg),
		.rx_ok(rx_ok), .rx_cnt(rx_cnt)
	);

	// ----------------------------------------
	// Clock, drive-time monitor, watchdog
	// ----------------------------------------
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// Cycles the host drives the line in its last frame
	always @(posedge clk)
	begin
		if (cmd_oe && !oe_prev)
			oe_len <= 16'h0001;
		else if (cmd_oe)
			oe_len <= oe_len + 16'h0001;
		oe_prev <= cmd_oe;
	end

	// All scenarios need about 22k cycles; the 40k-cycle limit leaves a wide margin
	initial
	begin
		#400_000;
		error_cnt++;
		end_of_test();
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic end_of_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Present one request on a falling edge and hold it over the accepting edge
	task automatic issue(input logic [5:0] idx, input logic [31:0] arg);
		int w;
		w = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && w < 100)
		begin
			@(negedge clk);
			w++;
		end
		cmd_valid = 1'b1;
		cmd_index = idx;
		cmd_arg   = arg;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	// Bounded wait for the completion pulse; lat counts cycles after accept
	task automatic wait_done(output int lat);
		lat = 0;
		do
		begin
			@(negedge clk);
			lat++;
		end while (done !== 1'b1 && lat < 3000);
		`CHK("done", 1'b1, done)
		`CHK("ready_back", 1'b1, cmd_ready)
	endtask

	function automatic sdcf_ctype_e exp_type(input logic [5:0] idx);
		case (idx)
			6'h00, 6'h01, 6'h04:        return CT_BC;
			6'h02, 6'h03, 6'h05, 6'h08: return CT_BCR;
			6'h0E, 6'h13:               return CT_ADTC;
			default:                    return CT_AC;
		endcase
	endfunction

	function automatic sdcf_rsp_e exp_rsp(input logic [5:0] idx);
		case (idx)
			6'h00, 6'h04, 6'h0F: return RSP_NONE;
			6'h01, 6'h05:        return RSP_SHORT_NOCRC;
			6'h02, 6'h09, 6'h0A: return RSP_LONG;
			default:             return RSP_SHORT;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Every basic command back to back plus one unlisted index, frame and answer checked
	task automatic t_table();
		logic [5:0]   ids [17] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
			6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h13, 6'h11};
		logic [31:0]  arg, sent;
		logic [127:0] lp;
		sdcf_rsp_e    k;
		int           lat;
		dly   = 8'h02;
		fault = 2'h0;
		foreach (ids[j])
		begin
			arg  = 32'hF0E1_D2C3 ^ {26'h0, ids[j]};
			sent = (ids[j] == 6'h08) ? {20'h0_0000, arg[11:0]} : arg;
			lp   = {~sent, sent, ~sent, sent};
			k    = exp_rsp(ids[j]);
			issue(ids[j], arg);
			wait_done(lat);
			`CHK("cmd_type", exp_type(ids[j]), cmd_type)
			`CHK("data_xfer", ids[j] inside {6'h0E, 6'h13}, data_xfer)
			`CHK("busy_expected", ids[j] inside {6'h06, 6'h07, 6'h0C}, busy_expected)
			`CHK("card_frame", 1'b1, rx_ok)
			`CHK("card_index", ids[j], rx_index)
			`CHK("card_arg", sent, rx_arg)
			`CHK("oe_len", 16'h0180, oe_len)
			`CHK("rsp_got", k != RSP_NONE, rsp_got)
			`CHK("crc_err", 1'b0, crc_err)
			`CHK("frame_err", 1'b0, frame_err)
			`CHK("timeout", 1'b0, timeout)
			if (k == RSP_LONG)
				`CHK("long_data", {lp[127:8], 1'b1}, {rsp_data[127:8], rsp_data[0]})
			else if (k != RSP_NONE)
				`CHK("short_data", {96'h0, ~sent, ids[j]}, {rsp_data, rsp_index})
			else
				`CHK("quick_done", 1'b1, lat < 420)
		end
	endtask

	// Bad checksum, bad end bit and a silent card
	task automatic t_faults();
		logic [5:0] fi [6] = '{6'h0D, 6'h0D, 6'h0D, 6'h09, 6'h01, 6'h02};
		logic [1:0] ff [6] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h1, 2'h3};
		int         lat;
		dly = 8'h02;
		foreach (fi[j])
		begin
			fault = ff[j];
			issue(fi[j], 32'h1234_5678);
			wait_done(lat);
			`CHK("crc_fault", ff[j] == 2'h1, crc_err)
			`CHK("end_fault", ff[j] == 2'h3, frame_err)
			`CHK("no_answer", ff[j] == 2'h2, timeout)
			`CHK("got_fault", ff[j] != 2'h2, rsp_got)
			if (ff[j] == 2'h2)
				`CHK("tmo_time", 1'b1, lat >= 890 && lat <= 930)
		end
		fault = 2'h0;
	endtask

	// Late answer inside the window, with a refused request meanwhile
	task automatic t_slow();
		logic [7:0] n0;
		int         lat;
		dly = 8'h3A;
		n0  = rx_cnt;
		issue(6'h0D, 32'hBEEF_0000);
		repeat (100) @(negedge clk);
		`CHK("ready_low", 1'b0, cmd_ready)
		cmd_valid = 1'b1;
		cmd_index = 6'h00;
		repeat (50) @(negedge clk);
		cmd_valid = 1'b0;
		wait_done(lat);
		`CHK("slow_tmo", 1'b0, timeout)
		`CHK("slow_got", 1'b1, rsp_got)
		`CHK("refused_cnt", n0 + 8'h01, rx_cnt)
		`CHK("refused_type", CT_AC, cmd_type)
		dly = 8'h02;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		error_cnt    = 0;
		total_checks = 0;
		rstn         = 1'b0;
		cmd_valid    = 1'b0;
		cmd_index    = 6'h00;
		cmd_arg      = 32'h0000_0000;
		dly          = 8'h02;
		fault        = 2'h0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		t_table();
		t_faults();
		t_slow();
		end_of_test();
	end
endmodule

`undef CHK
`default_nettype wire
